// ---- asct_pkg.sv ----
// shared constants and carrier types for the sample/conversion timing engine
package asct_pkg;
   // sample tick source select
   localparam logic [1:0] SRC_INTERNAL = 2'h0;  // divided sample timebase
   localparam logic [1:0] SRC_PIN      = 2'h1;  // synchronised sample clock pin
   localparam logic [1:0] SRC_OTHER    = 2'h2;  // other internal signal
   // timebase selects
   localparam logic [1:0] TB_FAST      = 2'h0;  // fast reference timebase
   localparam logic [1:0] TB_SLOW      = 2'h1;  // slow reference timebase
   localparam logic [1:0] TB_EXT       = 2'h2;  // external pin
   // clock and timing figures
   localparam int CLK_PERIOD_NS    = 100;
   localparam int HOLD_LEAD_MIN_NS = 50;       // hold pulse lead, least
   localparam int HOLD_WIDTH_MIN_NS = 400;     // hold pulse width, least
   localparam int HOLD_WIDTH_MAX_NS = 500;     // hold pulse width, most
   // lead rounds up to whole cycles, at least one
   localparam int HOLD_LEAD_CYC = (HOLD_LEAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // width between 400 and 500 ns: rounded up from the least, HOLD_WIDTH_MAX_NS not applied
   localparam int HOLD_WIDTH_CYC = (HOLD_WIDTH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_SLOW_MS   = 10;
   localparam int STROBE_SLOW_CYC  = STROBE_SLOW_MS * 1000000 / CLK_PERIOD_NS;
   localparam int STROBE_PULSES    = 8;
   localparam int DEFAULT_DELAY    = 2;        // start delay in timebase periods
   localparam int CNT_W            = 16;

   // acquisition configuration
   typedef struct packed {
      logic [1:0]       sample_src;
      logic             sample_edge_fall;
      logic [1:0]       sample_tb_sel;
      logic             sample_tb_fall;
      logic [CNT_W-1:0] sample_div;
      logic [CNT_W-1:0] sample_delay;
      logic [1:0]       conv_src;         // internal, pin, counter zero
      logic             conv_edge_fall;
      logic             conv_tb_master;
      logic [CNT_W-1:0] conv_div;
      logic [CNT_W-1:0] conv_delay;
      logic [7:0]       chan_count;
      logic             master_ext;
      logic             pause_src_cmp;
      logic             pause_high;
      logic             finite;
      logic [CNT_W-1:0] sample_total;
   } asct_cfg_t;

   // sequencer states, gray along start and run path; the return from sample to idle flips both bits
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ARMED = 2'b01,
      ST_SAMP  = 2'b11
   } asct_state_t;
endpackage

// ---- asct_core.sv ----
// sample and conversion tick timing engine with output pins
//
// Contract
// [R1] pause acts on level, polarity selectable
// [R2] comparator pause halts internal sample clock
// [R3] each sample converts whole channel list once
// [R4] sample tick edge selectable
// [R5] default sample tick from divided timebase
// [R6] sample pin input default, mirrors ticks
// [R7] level mode: high from start to last
// [R8] sample counter started by start, stops
// [R9] start to first sample delay, default two
// [R10] sample timebase fast, slow or external
// [R11] conversion edge selectable, one per tick
// [R12] internal conversion: counter zero or divider
// [R13] conversion timebase: sample or master
// [R14] conversion divider starts on sample, reloads
// [R15] conversion pin input default, mirrors ticks
// [R16] sample to first conversion delay, default two
// [R17] ticks ignored before start trigger
// [R18] extra sample ticks ignored mid-sample
// [R19] conversion ticks gated outside sample
// [R20] master timebase fast or sync line
// [R21] hold pulse 50-100 ns lead, 400-500 width
// [R22] strobe level or eight-pulse burst
// [R23] conversions per sample equal channel count
`timescale 1ns/1ps
module asct_core #(
   parameter int STROBE_SLOW = asct_pkg::STROBE_SLOW_CYC, // 10 ms burst half period, so a 20 ms pulse period
   parameter int STROBE_FAST = 12                          // short burst half period
) (
   input  wire logic                i_clk,
   input  wire logic                i_rst,
   input  wire logic                i_ce,              // freezes all state when low
   input  wire asct_pkg::asct_cfg_t i_cfg,
   input  wire logic                i_start,           // start trigger, one-cycle pulse
   input  wire logic                i_stop,            // software stop, one-cycle pulse
   input  wire logic                i_fast_tb,         // fast reference timebase
   input  wire logic                i_slow_tb,         // slow reference timebase
   input  wire logic                i_ext_tb,          // external timebase pin
   input  wire logic                i_sync_line,       // synchronisation bus line
   input  wire logic                i_pause_pin,       // pause gate from pin
   input  wire logic                i_cmp_event,       // analog comparator event
   input  wire logic                i_other_tick,      // other internal sample source
   input  wire logic                i_ctr0_out,        // counter zero output
   input  wire logic                i_samp_pin_in,     // sample clock pin level
   input  wire logic                i_conv_pin_in,     // conversion clock pin level
   input  wire logic                i_samp_pin_out,    // sample pin set as output
   input  wire logic                i_samp_level_mode, // level behaviour on sample pin
   input  wire logic                i_conv_pin_out,    // conversion pin set as output
   input  wire logic                i_hold_en,
   input  wire logic                i_hold_active_low,
   input  wire logic                i_strobe_hw,       // hardware strobe mode
   input  wire logic                i_strobe_fast,     // short-period clock for burst
   input  wire logic                i_strobe_go,       // burst request, one-cycle pulse
   input  wire logic                i_strobe_level,    // software strobe level
   output logic                     o_samp_pin,
   output logic                     o_samp_pin_oe,
   output logic                     o_conv_pin,
   output logic                     o_conv_pin_oe,
   output logic                     o_conv_start,      // conversion start pulse
   output logic                     o_hold_pin,
   output logic                     o_strobe_pin,
   output logic                     o_running,         // acquisition armed
   output logic                     o_done             // finite acquisition completed
);
   localparam int CW = asct_pkg::CNT_W;

   // two-stage synchronisers for all outside levels
   logic [9:0] sync1;
   logic [9:0] sync2;
   logic [9:0] pins;
   assign pins = {i_fast_tb, i_slow_tb, i_ext_tb, i_sync_line, i_pause_pin,
                  i_cmp_event, i_other_tick, i_ctr0_out, i_samp_pin_in, i_conv_pin_in};
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sync1 <= 10'h000;
         sync2 <= 10'h000;
      end else if (i_ce) begin
         sync1 <= pins;
         sync2 <= sync1;
      end
   end
   logic s_fast, s_slow, s_ext, s_sync, s_pause, s_cmp, s_other, s_ctr0, s_spin, s_cpin;
   assign {s_fast, s_slow, s_ext, s_sync, s_pause, s_cmp, s_other, s_ctr0, s_spin, s_cpin} = sync2;

   // edge detection on synchronised levels
   function automatic logic edge_hit(input logic now, input logic was, input logic fall);
      edge_hit = fall ? (was & ~now) : (now & ~was);
   endfunction

   // timebase selection
   logic samp_tb, master_tb;
   always_comb begin
      unique case (i_cfg.sample_tb_sel)
         asct_pkg::TB_SLOW: samp_tb = s_slow;
         asct_pkg::TB_EXT:  samp_tb = s_ext;
         default:           samp_tb = s_fast;                         // see [R10]
      endcase
      master_tb = i_cfg.master_ext ? s_sync : s_fast;                 // see [R20]
   end

   // delayed copies for edges
   logic samp_tb_d, master_tb_d, samp_src_d, conv_src_d;
   logic samp_tb_ev, conv_tb_ev;
   assign samp_tb_ev = edge_hit(samp_tb, samp_tb_d, i_cfg.sample_tb_fall);      // see [R10]
   // conversion timebase: sample timebase or master timebase
   assign conv_tb_ev = i_cfg.conv_tb_master ? edge_hit(master_tb, master_tb_d, 1'b0)
                                            : samp_tb_ev;                       // see [R13]

   // pause gate is a level, never an edge
   logic pause_lvl, paused;
   assign pause_lvl = i_cfg.pause_src_cmp ? s_cmp : s_pause;
   assign paused    = (pause_lvl == i_cfg.pause_high);                          // see [R1]

   // sequencer and counters
   asct_pkg::asct_state_t state, next_state;
   logic [CW-1:0] samp_cnt, next_samp_cnt;    // internal sample divider
   logic [CW-1:0] conv_cnt, next_conv_cnt;    // conversion divider
   logic [7:0]    conv_left, next_conv_left;  // conversions still owed
   logic [CW-1:0] samp_left, next_samp_left;  // finite sample count
   logic          samp_raw, conv_raw;          // selected, ungated ticks
   logic          int_samp_tick, int_conv_tick;
   logic          samp_acc, conv_acc;
   logic          samp_src_lvl, conv_src_lvl;
   logic          next_done;

   // internal sample divider halts while paused (comparator or pin)
   assign int_samp_tick = (state == asct_pkg::ST_ARMED) && samp_tb_ev && !paused
                          && (samp_cnt == '0);                                  // see [R2]
   always_comb begin
      samp_src_lvl = (i_cfg.sample_src == asct_pkg::SRC_PIN) ? s_spin : s_other;
      conv_src_lvl = (i_cfg.conv_src == 2'h1) ? s_cpin : s_ctr0;               // see [R12]
      // default source is the divider; others by edge choice
      if (i_cfg.sample_src == asct_pkg::SRC_INTERNAL) begin
         samp_raw = int_samp_tick;                                              // see [R5]
      end else begin
         samp_raw = edge_hit(samp_src_lvl, samp_src_d, i_cfg.sample_edge_fall) && !paused; // see [R4]
      end
      if (i_cfg.conv_src == 2'h0) begin
         conv_raw = int_conv_tick;                                              // see [R12]
      end else begin
         conv_raw = edge_hit(conv_src_lvl, conv_src_d, i_cfg.conv_edge_fall);   // see [R11]
      end
   end

   // gating: nothing before start, one sample at a time
   assign samp_acc = (state == asct_pkg::ST_ARMED) && samp_raw;                 // see [R17] [R18]
   assign conv_acc = (state == asct_pkg::ST_SAMP) && conv_raw && (conv_left != 8'h00); // see [R19]
   assign int_conv_tick = (state == asct_pkg::ST_SAMP) && conv_tb_ev && (conv_cnt == '0);

   // next-state logic for the sequencer
   always_comb begin
      next_state      = state;
      next_samp_cnt   = samp_cnt;
      next_conv_cnt   = conv_cnt;
      next_conv_left  = conv_left;
      next_samp_left  = samp_left;
      next_done       = o_done;
      unique case (state)
         asct_pkg::ST_IDLE: begin
            if (i_start) begin                                                  // see [R8]
               next_state      = asct_pkg::ST_ARMED;
               next_samp_cnt   = i_cfg.sample_delay - 1'b1;                      // see [R9]
               next_samp_left  = i_cfg.sample_total;
               next_done       = 1'b0;
            end
         end
         asct_pkg::ST_ARMED: begin
            // divider counts only while not paused
            if (samp_tb_ev && !paused) begin
               next_samp_cnt = (samp_cnt == '0) ? i_cfg.sample_div - 1'b1 : samp_cnt - 1'b1;
            end
            if (samp_acc) begin
               next_state      = asct_pkg::ST_SAMP;
               next_conv_cnt   = i_cfg.conv_delay - 1'b1;                        // see [R16]
               next_conv_left  = i_cfg.chan_count;                               // see [R23] [R3]
            end
         end
         asct_pkg::ST_SAMP: begin
            // conversion divider counts down and reloads during the sample
            if (conv_tb_ev) begin
               next_conv_cnt = (conv_cnt == '0) ? i_cfg.conv_div - 1'b1 : conv_cnt - 1'b1; // see [R14]
            end
            if (conv_acc) begin
               next_conv_left  = conv_left - 8'h01;
               if (conv_left == 8'h01) begin
                  next_conv_cnt = i_cfg.conv_delay - 1'b1;                       // see [R14]
                  if (i_cfg.finite && samp_left == 16'h0001) begin
                     next_state = asct_pkg::ST_IDLE;                            // see [R8]
                     next_done  = 1'b1;
                  end else begin
                     next_state = asct_pkg::ST_ARMED;
                  end
                  next_samp_left = samp_left - 16'h0001;
               end
            end
         end
         default: next_state = asct_pkg::ST_IDLE;
      endcase
      if (i_stop) begin
         next_state = asct_pkg::ST_IDLE;                                        // see [R8]
      end
   end

   // registered sequencer state
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state       <= asct_pkg::ST_IDLE;
         samp_cnt    <= '0;
         conv_cnt    <= '0;
         conv_left   <= 8'h00;
         samp_left   <= '0;
         o_done      <= 1'b0;
         samp_tb_d   <= 1'b0;
         master_tb_d <= 1'b0;
         samp_src_d  <= 1'b0;
         conv_src_d  <= 1'b0;
      end else if (i_ce) begin
         state       <= next_state;
         samp_cnt    <= next_samp_cnt;
         conv_cnt    <= next_conv_cnt;
         conv_left   <= next_conv_left;
         samp_left   <= next_samp_left;
         o_done      <= next_done;
         samp_tb_d   <= samp_tb;
         master_tb_d <= master_tb;
         samp_src_d  <= samp_src_lvl;
         conv_src_d  <= conv_src_lvl;
      end
   end

   // pin mirrors, hold pulse and strobe burst
   logic       next_samp_pin, next_conv_pin, next_conv_start, next_hold;
   logic [3:0] hold_cnt, next_hold_cnt;            // lead plus width
   logic [3:0] strobe_left, next_strobe_left;       // half periods owed
   logic [31:0] strobe_cnt, next_strobe_cnt;
   logic       next_strobe;
   logic       strobe_hw_lvl, next_strobe_hw_lvl;
   localparam logic [3:0] HOLD_TOTAL = 4'(asct_pkg::HOLD_LEAD_CYC + asct_pkg::HOLD_WIDTH_CYC);
   localparam logic [3:0] HOLD_LEAD  = 4'(asct_pkg::HOLD_LEAD_CYC);

   always_comb begin
      // level mode: high from start trigger until the last conversion of the first sample
      if (i_samp_level_mode) begin
         next_samp_pin = o_samp_pin;
         if (state == asct_pkg::ST_IDLE && i_start) next_samp_pin = 1'b1;      // see [R7]
         if (conv_acc && conv_left == 8'h01) next_samp_pin = 1'b0;             // see [R7]
      end else begin
         next_samp_pin = samp_acc;                                             // see [R6]
      end
      next_conv_pin   = conv_acc;                                              // see [R15]
      next_conv_start = conv_acc;                                              // see [R11]
      // hold pulse counts lead then width after each conversion start
      next_hold_cnt = (hold_cnt != 4'h0) ? hold_cnt - 4'h1 : 4'h0;
      if (conv_acc && i_hold_en) next_hold_cnt = HOLD_TOTAL;                    // see [R21]
      // decoded from the count being loaded, so the lead stays at one cycle
      next_hold = ((next_hold_cnt != 4'h0) && (next_hold_cnt <= HOLD_TOTAL - HOLD_LEAD))
                  ^ i_hold_active_low;                                         // see [R21]
      // strobe burst: eight pulses, fifteen half periods
      next_strobe_left   = strobe_left;
      next_strobe_cnt    = strobe_cnt;
      next_strobe_hw_lvl = strobe_hw_lvl;
      if (i_strobe_go && i_strobe_hw && strobe_left == 4'h0) begin
         next_strobe_left   = 4'(2 * asct_pkg::STROBE_PULSES - 1);              // see [R22]
         next_strobe_cnt    = 32'(i_strobe_fast ? STROBE_FAST : STROBE_SLOW) - 1;
         next_strobe_hw_lvl = 1'b1;
      end else if (strobe_hw_lvl || strobe_left != 4'h0) begin
         if (strobe_cnt == 32'h0000_0000) begin
            next_strobe_cnt    = 32'(i_strobe_fast ? STROBE_FAST : STROBE_SLOW) - 1;
            next_strobe_hw_lvl = (strobe_left != 4'h0) ? ~strobe_hw_lvl : 1'b0;
            next_strobe_left   = (strobe_left != 4'h0) ? strobe_left - 4'h1 : 4'h0;
         end else begin
            next_strobe_cnt = strobe_cnt - 32'h0000_0001;
         end
      end
      next_strobe = i_strobe_hw ? next_strobe_hw_lvl : i_strobe_level;         // see [R22]
   end

   // registered outputs
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_samp_pin    <= 1'b0;
         o_samp_pin_oe <= 1'b0;
         o_conv_pin    <= 1'b0;
         o_conv_pin_oe <= 1'b0;
         o_conv_start  <= 1'b0;
         o_hold_pin    <= 1'b0;
         hold_cnt      <= 4'h0;
         strobe_left   <= 4'h0;
         strobe_cnt    <= 32'h0000_0000;
         strobe_hw_lvl <= 1'b0;
         o_strobe_pin  <= 1'b0;
         o_running     <= 1'b0;
      end else if (i_ce) begin
         o_samp_pin    <= next_samp_pin;
         o_samp_pin_oe <= i_samp_pin_out;                                       // see [R6]
         o_conv_pin    <= next_conv_pin;
         o_conv_pin_oe <= i_conv_pin_out;                                       // see [R15]
         o_conv_start  <= next_conv_start;
         o_hold_pin    <= i_hold_en ? next_hold : i_hold_active_low;
         hold_cnt      <= next_hold_cnt;
         strobe_left   <= next_strobe_left;
         strobe_cnt    <= next_strobe_cnt;
         strobe_hw_lvl <= next_strobe_hw_lvl;
         o_strobe_pin  <= next_strobe;
         o_running     <= (next_state != asct_pkg::ST_IDLE);
      end
   end
endmodule

// ---- asct_partner.sv ----
// far-side model: reference timebases, sync line and counter zero output
`timescale 1ns/1ps
module asct_partner (
   input  wire logic i_clk,
   input  wire logic i_rst,
   output logic      o_fast_tb,
   output logic      o_slow_tb,
   output logic      o_ext_tb,
   output logic      o_sync_line,
   output logic      o_ctr0_out
);
   logic [7:0] ticks;  // free-running phase count
   // timebases run free, they are clocks rather than framed links
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ticks <= 8'h00;
      end else begin
         ticks <= ticks + 8'h01;
      end
   end
   // edges spaced far apart so the two-flop synchronisers never alias
   assign o_fast_tb   = ticks[1];
   assign o_sync_line = ticks[1];
   assign o_ext_tb    = ticks[2];
   assign o_slow_tb   = ticks[4];
   assign o_ctr0_out  = (ticks[2:0] == 3'h7);  // one-cycle counter pulse
endmodule

// ---- asct_core_asserts.sv ----
// port-level assertions for the sample/conversion timing engine
`timescale 1ns/1ps
module asct_core_asserts (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_start,
   input wire logic i_stop,
   input wire logic i_samp_pin_out,
   input wire logic i_samp_level_mode,
   input wire logic i_conv_pin_out,
   input wire logic i_hold_en,
   input wire logic i_hold_active_low,
   input wire logic i_strobe_hw,
   input wire logic i_strobe_level,
   input wire logic o_samp_pin,
   input wire logic o_samp_pin_oe,
   input wire logic o_conv_pin,
   input wire logic o_conv_pin_oe,
   input wire logic o_conv_start,
   input wire logic o_hold_pin,
   input wire logic o_strobe_pin,
   input wire logic o_running,
   input wire logic o_done
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   a_start_arms: assert property (
      i_ce && i_start && !i_stop && !o_running |=> o_running)
      else $error("start trigger did not arm the engine");
   a_stop_halts: assert property (i_ce && i_stop |=> !o_running)
      else $error("stop left the engine running");
   a_done_idle: assert property (o_done |-> !o_running)
      else $error("engine running after finite end");
   a_conv_armed: assert property (o_conv_start |-> $past(o_running))
      else $error("conversion while not armed");
   a_hold_follow: assert property (
      o_conv_start && i_hold_en && !i_hold_active_low |=> o_hold_pin [*4])
      else $error("hold pulse too short or missing");
   a_hold_lead: assert property (
      $rose(o_hold_pin) && !i_hold_active_low |-> $past(o_conv_start))
      else $error("hold pulse lead wrong");
   a_samp_oe: assert property (i_ce |=> o_samp_pin_oe == $past(i_samp_pin_out))
      else $error("sample pin direction wrong");
   a_conv_oe: assert property (i_ce |=> o_conv_pin_oe == $past(i_conv_pin_out))
      else $error("conversion pin direction wrong");
   a_samp_brief: assert property (o_samp_pin && !i_samp_level_mode |=> !o_samp_pin)
      else $error("sample pin pulse longer than one cycle");
   a_conv_mirror: assert property (o_conv_pin_oe && o_conv_start |-> o_conv_pin)
      else $error("conversion pin missed a tick");
   a_strobe_soft: assert property (
      !i_strobe_hw ##1 !i_strobe_hw |-> o_strobe_pin == $past(i_strobe_level))
      else $error("strobe does not follow software level");
   // main scenarios reached
   c_done: cover property (o_done);
   c_hold: cover property ($rose(o_hold_pin));
   c_burst: cover property ($rose(o_strobe_pin) && i_strobe_hw);
endmodule
bind asct_core asct_core_asserts u_chk (.*);

// ---- tb_top.sv ----
// self-checking bench for the sample/conversion timing engine
`timescale 1ns/1ps
module tb_top;
   logic i_clk, i_rst, i_ce, i_start, i_stop, i_fast_tb, i_slow_tb, i_ext_tb, i_sync_line;
   logic i_pause_pin, i_cmp_event, i_other_tick, i_ctr0_out, i_samp_pin_in, i_conv_pin_in;
   logic i_samp_pin_out, i_samp_level_mode, i_conv_pin_out, i_hold_en, i_hold_active_low;
   logic i_strobe_hw, i_strobe_fast, i_strobe_go, i_strobe_level, samp_q, strb_q;
   logic o_samp_pin, o_samp_pin_oe, o_conv_pin, o_conv_pin_oe, o_conv_start;
   logic o_hold_pin, o_strobe_pin, o_running, o_done;
   asct_pkg::asct_cfg_t i_cfg;                           // acquisition setup
   int   fails, check_count, n_samp, n_conv, n_strb, k;  // tallies
   // short burst periods keep the run brief
   asct_core #(.STROBE_SLOW(20), .STROBE_FAST(12)) dut (.*);
   asct_partner u_far (.i_clk(i_clk), .i_rst(i_rst), .o_fast_tb(i_fast_tb),
      .o_slow_tb(i_slow_tb), .o_ext_tb(i_ext_tb), .o_sync_line(i_sync_line),
      .o_ctr0_out(i_ctr0_out));
   initial i_clk = 1'b0;
   always #50 i_clk = ~i_clk;
   // edge counters on the observed outputs
   // sampled at the falling edge, where the registered outputs have settled
   always @(negedge i_clk) begin
      samp_q <= o_samp_pin;
      strb_q <= o_strobe_pin;
      if (o_samp_pin === 1'b1 && samp_q === 1'b0) n_samp++;
      if (o_conv_start === 1'b1) n_conv++;
      if (o_strobe_pin === 1'b1 && strb_q === 1'b0) n_strb++;
   end
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         $display("CHECK FAILED %s expected %0d seen %0d", nm, exp, seen);
         fails++;
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   task automatic go_start;
      i_start = 1'b1; cyc(1); i_start = 1'b0;
   endtask
   task automatic go_stop;
      i_stop = 1'b1; cyc(1); i_stop = 1'b0; cyc(3);
   endtask
   // pin ticks held long enough to pass the synchronisers
   task automatic pin_tick(input bit conv);
      if (conv) i_conv_pin_in = 1'b1; else i_samp_pin_in = 1'b1;
      cyc(4); i_conv_pin_in = 1'b0; i_samp_pin_in = 1'b0; cyc(4);
   endtask
   task automatic base;
      i_cfg = '0; i_cfg.sample_div = 16'h000A; i_cfg.sample_delay = 16'h0002;
      i_cfg.conv_div = 16'h0002; i_cfg.conv_delay = 16'h0002; i_cfg.conv_tb_master = 1'b1;
      i_cfg.chan_count = 8'h03; i_cfg.finite = 1'b1; i_cfg.sample_total = 16'h0002;
      i_cfg.pause_high = 1'b1;  // pause pin idles low, so pause only on a high level
      i_samp_pin_out = 1'b1; i_samp_level_mode = 1'b0; cyc(4);
      n_samp = 0; n_conv = 0;
   endtask
   task automatic wait_done;
      for (k = 0; k < 3000 && o_done !== 1'b1; k++) cyc(1);
      chk("done flag", o_done, 1);
      cyc(5);
   endtask
   task automatic t_finite;
      base(); i_hold_en = 1'b1;
      i_cfg.conv_tb_master = 1'b0;  // conversions timed from the sample timebase
      i_cfg.sample_tb_fall = 1'b1;  // falling timebase edges
      cyc(20);
      chk("conv before start", n_conv, 0);
      go_start(); wait_done();
      chk("samples", n_samp, 2);
      chk("conversions", n_conv, 6);
      chk("running after end", o_running, 0);
   endtask
   task automatic t_level;
      base(); i_cfg.master_ext = 1'b1; i_cfg.sample_total = 16'h0001;
      i_cfg.chan_count = 8'h02; i_samp_level_mode = 1'b1; cyc(2);
      go_start(); cyc(4);
      chk("level pin high", o_samp_pin, 1);
      wait_done();
      chk("level pin low", o_samp_pin, 0);
      chk("level conversions", n_conv, 2);
      i_samp_level_mode = 1'b0;
   endtask
   task automatic t_stop;
      base(); i_cfg.finite = 1'b0; i_cfg.conv_src = 2'h2; i_cfg.sample_tb_sel = asct_pkg::TB_EXT;
      go_start();
      for (k = 0; k < 2000 && n_conv < 4; k++) cyc(1);
      chk("counter conversions", n_conv > 3, 1);
      go_stop(); k = n_conv; cyc(100);
      chk("conv after stop", n_conv, k);
      chk("running after stop", o_running, 0);
   endtask
   task automatic t_gate;
      base(); i_cfg.finite = 1'b0; i_cfg.sample_src = asct_pkg::SRC_PIN;
      i_cfg.conv_src = 2'h1; i_cfg.chan_count = 8'h02; i_conv_pin_out = 1'b1;
      pin_tick(0); pin_tick(1);
      chk("ticks before start", n_conv, 0);
      go_start(); pin_tick(0); pin_tick(0);
      chk("extra sample ignored", n_samp, 1);
      repeat (3) pin_tick(1);
      chk("extra conv ignored", n_conv, 2);
      i_cfg.sample_edge_fall = 1'b1; i_cfg.conv_edge_fall = 1'b1;
      pin_tick(0); repeat (2) pin_tick(1);
      chk("second sample", n_samp, 2);
      chk("second sample convs", n_conv, 4);
      go_stop(); i_conv_pin_out = 1'b0;
   endtask
   task automatic t_pause;
      base(); i_cfg.finite = 1'b0; i_cfg.pause_src_cmp = 1'b1; i_cfg.pause_high = 1'b1;
      i_cmp_event = 1'b1; go_start(); cyc(200);
      chk("paused high", n_samp, 0);
      i_cmp_event = 1'b0; cyc(200);
      chk("resumed", n_samp > 0, 1);
      i_cfg.pause_high = 1'b0; cyc(40); k = n_samp; cyc(200);
      chk("paused low", n_samp, k);
      go_stop();
   endtask
   task automatic t_strobe;
      i_strobe_level = 1'b1; cyc(3);
      chk("strobe soft high", o_strobe_pin, 1);
      i_strobe_level = 1'b0; i_strobe_hw = 1'b1;
      for (int f = 0; f < 2; f++) begin
         i_strobe_fast = f[0]; cyc(2); n_strb = 0;
         i_strobe_go = 1'b1; cyc(1); i_strobe_go = 1'b0; cyc(400);
         chk("burst pulses", n_strb, 8);
      end
      i_strobe_hw = 1'b0;
   endtask
   // watchdog, about twenty times the expected run
   initial begin
      #(100 * 40000);
      fails++;
      wrap_up();
   end
   initial begin
      {i_rst, i_ce} = 2'b11;
      {i_start, i_stop, i_pause_pin, i_cmp_event, i_other_tick} = '0;
      {i_samp_pin_in, i_conv_pin_in, i_samp_pin_out, i_samp_level_mode, i_conv_pin_out} = '0;
      {i_hold_en, i_hold_active_low, i_strobe_hw, i_strobe_fast, i_strobe_go} = '0;
      i_strobe_level = 1'b0; i_cfg = '0; fails = 0; check_count = 0;
      cyc(2);
      chk("oe in reset", {o_samp_pin_oe, o_conv_pin_oe, o_running}, 0);
      i_rst = 1'b0;
      t_finite(); t_level(); t_stop(); t_gate(); t_pause(); t_strobe();
      wrap_up();
   end
endmodule
